// ---- logic/adc_regs_pkg.sv ----
package adc_regs_pkg;

  // Register addresses in the serial command byte
  localparam logic [4:0] ADDR_GPIO_CONTROL  = 5'h02;
  localparam logic [4:0] ADDR_CALIB_CONTROL = 5'h03;
  localparam logic [4:0] ADDR_RESULT        = 5'h04;
  localparam logic [4:0] ADDR_SYS_OFFSET    = 5'h05;
  localparam logic [4:0] ADDR_SYS_GAIN      = 5'h06;
  localparam logic [4:0] ADDR_SELF_OFFSET   = 5'h07;
  localparam logic [4:0] ADDR_SELF_GAIN     = 5'h08;

  // Command byte layout
  localparam int CMD_START_BIT = 7;
  localparam int CMD_MODE_BIT  = 6;
  localparam int CMD_ADDR_LSB  = 1;
  localparam int CMD_RW_BIT    = 0;

  // Field positions
  localparam int GPIO_DIR_LSB = 4;
  localparam int DIGITAL_GAIN_CODE_LSB    = 5;
  localparam int SYSG_DIS_BIT = 4;
  localparam int SYSO_DIS_BIT = 3;
  localparam int SCG_DIS_BIT  = 2;
  localparam int SCO_DIS_BIT  = 1;

  // Reset values and the calibration write mask
  localparam logic [7:0]  GPIO_CONTROL_RST  = 8'h0F;
  localparam logic [7:0]  CALIB_CONTROL_RST = 8'h1E;
  localparam logic [7:0]  CALIB_WRITE_MASK  = 8'hFE;
  localparam logic [23:0] COEF_RST          = 24'h000000;
  localparam logic [15:0] RESULT_RST        = 16'h0000;

  // Frame lengths in bits
  localparam logic [4:0] CMD_BITS   = 5'h08;
  localparam logic [4:0] BYTE_BITS  = 5'h08;
  localparam logic [4:0] WORD_BITS  = 5'h18;

  // Correction chain
  localparam int CHAIN_W      = 40;
  localparam int COEF_FRAC    = 23;
  localparam int RESULT_SHIFT = 8;
  localparam logic signed [CHAIN_W-1:0] UNI_MAX = 40'sh000000FFFF;
  localparam logic signed [CHAIN_W-1:0] BIP_MAX = 40'sh0000007FFF;
  localparam logic signed [CHAIN_W-1:0] BIP_MIN = -40'sh0000008000;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b10,
    PH_SKIP = 2'b11
  } phase_e;

endpackage

// ---- logic/pin_sync.sv ----
module pin_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Asynchronous pins and their synchronised copies
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // Two-stage chain; only the second stage is read outside
  always_comb begin
    st_next        = st_reg;
    st_next.first  = pin_in;
    st_next.second = st_reg.first;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pin_sync_out = st_reg.second;
endmodule

// ---- logic/coef_scaler.sv ----
module coef_scaler
  import adc_regs_pkg::*;
#(
  parameter int W = CHAIN_W
) (
  // Value, coefficient and bypass
  input  wire logic signed [W-1:0] value_in,
  input  wire logic        [23:0]  coef,
  input  wire logic                bypass,
  output logic signed      [W-1:0] value_out
);
  // Coefficient is a factor in [0,2) with 23 fraction bits
  logic signed [W+24:0] product;

  always_comb begin
    product   = value_in * $signed({1'b0, coef});
    value_out = bypass ? value_in : W'(product >>> COEF_FRAC);
  end
endmodule

// ---- logic/adc_gpio_calib_result_regs.sv ----
module adc_gpio_calib_result_regs
  import adc_regs_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // Serial port pins
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic               din,
  output logic                    dout,
  // GPIO pins
  input  wire logic [3:0]         gpio_in,
  output logic      [3:0]         gpio_out,
  output logic      [3:0]         gpio_oe,
  // Range and format selects
  input  wire logic               unipolar_sel,
  input  wire logic               offset_binary_sel,
  // Converter core samples
  input  wire logic               sample_valid,
  input  wire logic signed [23:0] raw_sample,
  output logic                    result_valid,
  // Calibration engine
  input  wire logic               cal_busy,
  input  wire logic               sys_offset_load,
  input  wire logic               sys_gain_load,
  input  wire logic               self_offset_load,
  input  wire logic               self_gain_load,
  input  wire logic [23:0]        cal_value
);
  typedef struct packed {
    logic [7:0]  gpio_ctrl;
    logic [7:0]  calib_ctrl;
    logic [23:0] sys_offset;
    logic [23:0] sys_gain;
    logic [23:0] self_offset;
    logic [23:0] self_gain;
    logic [15:0] result;
    logic        result_valid;
    phase_e      phase;
    logic [4:0]  bit_cnt;
    logic [7:0]  cmd;
    logic [23:0] rx;
    logic [23:0] tx;
    logic        sclk_prev;
    logic        dout;
  } state_s;

  localparam state_s STATE_RST = '{
    gpio_ctrl:   GPIO_CONTROL_RST,
    calib_ctrl:  CALIB_CONTROL_RST,
    sys_offset:  COEF_RST,
    sys_gain:    COEF_RST,
    self_offset: COEF_RST,
    self_gain:   COEF_RST,
    result:      RESULT_RST,
    result_valid: 1'b0,
    phase:       PH_IDLE,
    bit_cnt:     5'h00,
    cmd:         8'h00,
    rx:          24'h000000,
    tx:          24'h000000,
    sclk_prev:   1'b0,
    dout:        1'b0
  };

  state_s st_reg;
  state_s st_next;

  logic       sclk_s;
  logic       cs_n_s;
  logic       din_s;
  logic [3:0] gpio_s;

  // Serial and GPIO pins pass two flops first; the other inputs are used directly
  pin_sync #(.WIDTH(7)) u_pin_sync (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .pin_in       ({gpio_in, din, cs_n, sclk}),
    .pin_sync_out ({gpio_s, din_s, cs_n_s, sclk_s})
  );

  // Length of the data field for an address, zero if unmapped
  function automatic logic [4:0] reg_bits(input logic [4:0] addr);
    unique case (addr)
      ADDR_GPIO_CONTROL, ADDR_CALIB_CONTROL: reg_bits = BYTE_BITS;
      ADDR_RESULT, ADDR_SYS_OFFSET, ADDR_SYS_GAIN,
      ADDR_SELF_OFFSET, ADDR_SELF_GAIN:      reg_bits = WORD_BITS;
      default:                               reg_bits = 5'h00;
    endcase
  endfunction

  // Clamp and encode the corrected value into the 16-bit code
  function automatic logic [15:0] encode(input logic signed [CHAIN_W-1:0] v,
                                         input logic uni, input logic ob);
    logic [15:0] code;
    code = v[15:0];
    if (uni) begin
      if (v < 0) code = 16'h0000;
      else if (v > UNI_MAX) code = 16'hFFFF;
    end else begin
      if (v < BIP_MIN) code = 16'h8000;
      else if (v > BIP_MAX) code = 16'h7FFF;
      if (ob) code = code ^ SIGN_FLIP;
    end
    return code;
  endfunction

  // GPIO read-back: inputs show the pin, outputs the stored level
  logic [3:0] gpio_dir;
  logic [3:0] gpio_rd;
  assign gpio_dir = st_reg.gpio_ctrl[GPIO_DIR_LSB +: 4];
  assign gpio_rd  = (gpio_dir & st_reg.gpio_ctrl[3:0]) | (~gpio_dir & gpio_s);

  // Read image of an address, left aligned in 24 bits
  function automatic logic [23:0] read_value(input logic [4:0] addr, input state_s s,
                                             input logic [3:0] gpio_view);
    unique case (addr)
      ADDR_GPIO_CONTROL:  read_value = {s.gpio_ctrl[7:4], gpio_view, 16'h0000};
      ADDR_CALIB_CONTROL: read_value = {s.calib_ctrl, 16'h0000};
      ADDR_RESULT:        read_value = {s.result, 8'h00};
      ADDR_SYS_OFFSET:    read_value = s.sys_offset;
      ADDR_SYS_GAIN:      read_value = s.sys_gain;
      ADDR_SELF_OFFSET:   read_value = s.self_offset;
      ADDR_SELF_GAIN:     read_value = s.self_gain;
      default:            read_value = 24'h000000;
    endcase
  endfunction

  // Correction chain in documented order
  logic                       uni_s;
  logic signed [CHAIN_W-1:0] raw_x;
  logic signed [CHAIN_W-1:0] after_sco;
  logic signed [CHAIN_W-1:0] after_scg;
  logic signed [CHAIN_W-1:0] after_soc;
  logic signed [CHAIN_W-1:0] scaled;
  logic signed [CHAIN_W-1:0] after_sg;
  logic signed [CHAIN_W-1:0] after_dg;
  logic signed [CHAIN_W-1:0] final_v;
  logic [2:0]                 digital_gain_code;

  assign uni_s     = unipolar_sel;
  assign digital_gain_code     = st_reg.calib_ctrl[DIGITAL_GAIN_CODE_LSB +: 3];
  assign raw_x     = CHAIN_W'(raw_sample);
  assign after_sco = st_reg.calib_ctrl[SCO_DIS_BIT] ? raw_x
                   : raw_x - CHAIN_W'($signed(st_reg.self_offset));

  coef_scaler u_self_gain (
    .value_in  (after_sco),
    .coef      (st_reg.self_gain),
    .bypass    (st_reg.calib_ctrl[SCG_DIS_BIT]),
    .value_out (after_scg)
  );

  assign after_soc = st_reg.calib_ctrl[SYSO_DIS_BIT] ? after_scg
                   : after_scg - CHAIN_W'($signed(st_reg.sys_offset));
  assign scaled    = uni_s ? (after_soc <<< 1) : after_soc;

  coef_scaler u_sys_gain (
    .value_in  (scaled),
    .coef      (st_reg.sys_gain),
    .bypass    (st_reg.calib_ctrl[SYSG_DIS_BIT]),
    .value_out (after_sg)
  );

  assign after_dg = after_sg <<< digital_gain_code;
  assign final_v  = after_dg >>> RESULT_SHIFT;

  // Serial decode, register writes, calibration loads and result capture
  logic        rise;
  logic        fall;
  logic [7:0]  cmd_byte;
  logic [4:0]  cur_addr;
  logic [23:0] wr_data;
  logic        wr_commit;

  always_comb begin
    st_next              = st_reg;
    st_next.result_valid = 1'b0;
    st_next.sclk_prev    = sclk_s;
    rise      = sclk_s & ~st_reg.sclk_prev;
    fall      = ~sclk_s & st_reg.sclk_prev;
    cmd_byte  = {st_reg.cmd[6:0], din_s};
    cur_addr  = st_reg.cmd[CMD_ADDR_LSB +: 5];
    wr_data   = {st_reg.rx[22:0], din_s};
    wr_commit = 1'b0;
    if (cs_n_s) begin
      st_next.phase   = PH_IDLE;
      st_next.bit_cnt = 5'h00;
      st_next.dout    = 1'b0;
    end else begin
      unique case (st_reg.phase)
        PH_IDLE: begin
          st_next.phase   = PH_CMD;
          st_next.bit_cnt = 5'h00;
        end
        PH_CMD: begin
          if (rise) begin
            st_next.cmd     = cmd_byte;
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == CMD_BITS - 5'h01) begin
              st_next.bit_cnt = 5'h00;
              if (cmd_byte[CMD_START_BIT] && cmd_byte[CMD_MODE_BIT] &&
                  reg_bits(cmd_byte[CMD_ADDR_LSB +: 5]) != 5'h00) begin
                st_next.phase = PH_DATA;
                st_next.tx    = cmd_byte[CMD_RW_BIT]
                              ? read_value(cmd_byte[CMD_ADDR_LSB +: 5], st_reg, gpio_rd)
                              : 24'h000000;
              end else begin
                st_next.phase = PH_SKIP;
              end
            end
          end
        end
        PH_DATA: begin
          if (fall) begin
            st_next.dout = st_reg.tx[23];
            st_next.tx   = {st_reg.tx[22:0], 1'b0};
          end
          if (rise) begin
            st_next.rx      = wr_data;
            st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
            if (st_reg.bit_cnt == reg_bits(cur_addr) - 5'h01) begin
              st_next.phase = PH_SKIP;
              wr_commit     = ~st_reg.cmd[CMD_RW_BIT];
            end
          end
        end
        PH_SKIP: begin
          st_next.dout = 1'b0;
        end
      endcase
    end
    // Host writes; the result register takes none
    if (wr_commit) begin
      unique case (cur_addr)
        ADDR_GPIO_CONTROL:  st_next.gpio_ctrl   = wr_data[7:0];
        ADDR_CALIB_CONTROL: st_next.calib_ctrl  = wr_data[7:0] & CALIB_WRITE_MASK;
        ADDR_SYS_OFFSET:    st_next.sys_offset  = wr_data;
        ADDR_SYS_GAIN:      st_next.sys_gain    = wr_data;
        ADDR_SELF_OFFSET:   st_next.self_offset = wr_data;
        ADDR_SELF_GAIN:     if (!cal_busy) st_next.self_gain = wr_data;
        default: ;
      endcase
    end
    // Measured coefficients replace host values
    if (sys_offset_load)  st_next.sys_offset  = cal_value;
    if (sys_gain_load)    st_next.sys_gain    = cal_value;
    if (self_offset_load) st_next.self_offset = cal_value;
    if (self_gain_load)   st_next.self_gain   = cal_value;
    if (sample_valid) begin
      st_next.result       = encode(final_v, uni_s, offset_binary_sel);
      st_next.result_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= STATE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops
  assign dout         = st_reg.dout;
  assign gpio_oe      = st_reg.gpio_ctrl[GPIO_DIR_LSB +: 4];
  assign gpio_out     = st_reg.gpio_ctrl[3:0];
  assign result_valid = st_reg.result_valid;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_result_ro;
    (wr_commit && cur_addr == ADDR_RESULT && !sample_valid) |=> $stable(st_reg.result);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result changed by write");

  property p_gpio_in_read;
    (gpio_dir[0] == 1'b0) |-> (gpio_rd[0] == gpio_s[0]);
  endproperty
  a_gpio_in_read: assert property (p_gpio_in_read) else $error("input gpio read wrong");

  property p_gpio_drive;
    (wr_commit && cur_addr == ADDR_GPIO_CONTROL)
      |=> (gpio_oe == $past(wr_data[7:4])) && (gpio_out == $past(wr_data[3:0]));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive mismatch");

  property p_uni_clamp;
    (sample_valid && uni_s && final_v > UNI_MAX) |=> (st_reg.result == 16'hFFFF);
  endproperty
  a_uni_clamp: assert property (p_uni_clamp) else $error("unipolar not clamped");

  property p_bip_neg_clamp;
    (sample_valid && !uni_s && !offset_binary_sel && final_v < BIP_MIN)
      |=> (st_reg.result == 16'h8000) && result_valid;
  endproperty
  a_bip_neg_clamp: assert property (p_bip_neg_clamp) else $error("bipolar low clamp wrong");

  property p_offset_binary;
    (sample_valid && !uni_s && offset_binary_sel && final_v == 0)
      |=> (st_reg.result == 16'h8000);
  endproperty
  a_offset_binary: assert property (p_offset_binary) else $error("offset binary zero wrong");

  property p_sys_offset_skip;
    st_reg.calib_ctrl[SYSO_DIS_BIT] |-> (after_soc == after_scg);
  endproperty
  a_sys_offset_skip: assert property (p_sys_offset_skip) else $error("system offset used");

  property p_digital_gain_code_shift;
    (digital_gain_code == 3'h7) |-> (after_dg == (after_sg <<< 7));
  endproperty
  a_digital_gain_code_shift: assert property (p_digital_gain_code_shift) else $error("digital gain shift wrong");

  sequence s_cal_load;
    sys_offset_load ##1 1'b1;
  endsequence
  property p_cal_load;
    s_cal_load |-> (st_reg.sys_offset == $past(cal_value));
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("system offset not loaded");
endmodule

// ---- bench/spi_host_model.sv ----
module spi_host_model (
  // Clock
  input  wire logic ref_clk,
  // Serial pins of the host
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 1ns;

  // Ref_clk cycles per sclk phase; the bench may slow the host down
  int half = 6;

  // Idle pins: select high, clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // Command byte then n data bits; dout taken just before each data rise
  task automatic frame(input logic [7:0] cmd, input int n, input logic [23:0] wdata,
                       output logic [23:0] rdata);
    rdata = 24'h000000;
    @(negedge ref_clk);
    cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      din = (i < 8) ? cmd[7 - i] : wdata[n + 7 - i];
      repeat (half) @(negedge ref_clk);
      if (i >= 8) rdata = {rdata[22:0], dout};
      sclk = 1'b1;
      repeat (half) @(negedge ref_clk);
      sclk = 1'b0;
    end
    repeat (half) @(negedge ref_clk);
    cs_n = 1'b1;
    // Released line shows the inverse, never a held value
    din = ~din;
    repeat (half) @(negedge ref_clk);
  endtask
endmodule

// ---- bench/adc_gpio_calib_result_regs_tb_top.sv ----
module adc_gpio_calib_result_regs_tb_top
  import adc_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Design pins
  logic               ref_clk;
  logic               reset;
  logic               sclk;
  logic               cs_n;
  logic               din;
  logic               dout;
  logic [3:0]         gpio_in;
  logic [3:0]         gpio_out;
  logic [3:0]         gpio_oe;
  logic               unipolar_sel;
  logic               offset_binary_sel;
  logic               sample_valid;
  logic signed [23:0] raw_sample;
  logic               result_valid;
  logic               cal_busy;
  logic [3:0]         loads;
  logic [23:0]        cal_value;
  // Mirrored register contents and counters
  logic [7:0]         ctl3;
  logic [23:0]        soc;
  logic [23:0]        system_gain_coefficient;
  logic [23:0]        sco;
  logic [23:0]        scg;
  logic [23:0]        rd;
  logic [7:0]         v8;
  int                 fail_count;
  int                 check_count;
  int                 cycles = 0;
  logic signed [23:0] corner [5] = '{24'sh000000, 24'sh400000, 24'sh7FFFFF,
                                     24'sh800000, 24'shC00000};

  adc_gpio_calib_result_regs adc_gpio_calib_result_regs_inst (
    .ref_clk(ref_clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .unipolar_sel(unipolar_sel), .offset_binary_sel(offset_binary_sel),
    .sample_valid(sample_valid), .raw_sample(raw_sample), .result_valid(result_valid),
    .cal_busy(cal_busy), .sys_offset_load(loads[0]), .sys_gain_load(loads[1]),
    .self_offset_load(loads[2]), .self_gain_load(loads[3]), .cal_value(cal_value)
  );

  spi_host_model spi_host_model_inst (
    .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout)
  );

  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fail_count++;
      summarize();
    end
  end

  // Verdict and end of run
  task automatic summarize();
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Compare and count
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register access through the host
  task automatic wr(input logic [4:0] a, input int n, input logic [23:0] v);
    logic [23:0] unused;
    spi_host_model_inst.frame({2'b11, a, 1'b0}, n, v, unused);
  endtask

  task automatic rd_reg(input logic [4:0] a, input int n, output logic [23:0] v);
    spi_host_model_inst.frame({2'b11, a, 1'b1}, n, 24'h000000, v);
  endtask

  // One-cycle coefficient load from the calibration engine
  task automatic pulse_load(input int k, input logic [23:0] v);
    cal_value = v;
    loads = 4'h1 << k;
    @(negedge ref_clk);
    loads = 4'h0;
    // Idle edge so a following pulse never reassigns in this step
    @(negedge ref_clk);
  endtask

  // Expected result code from the correction chain
  function automatic logic [15:0] expect_result(input logic signed [23:0] raw,
                                                input logic uni, input logic ob);
    longint v;
    longint lo;
    v = raw;
    if (!ctl3[SCO_DIS_BIT]) v = v - longint'($signed(sco));
    if (!ctl3[SCG_DIS_BIT]) v = (v * longint'(scg)) >>> 23;
    if (!ctl3[SYSO_DIS_BIT]) v = v - longint'($signed(soc));
    if (uni) v = v * 2;
    if (!ctl3[SYSG_DIS_BIT]) v = (v * longint'(system_gain_coefficient)) >>> 23;
    v = (v <<< ctl3[7:5]) >>> 8;
    lo = uni ? 64'sh0 : BIP_MIN;
    if (v < lo) v = lo;
    if (v > (uni ? UNI_MAX : BIP_MAX)) v = uni ? UNI_MAX : BIP_MAX;
    return (!uni && ob) ? (16'(v) ^ SIGN_FLIP) : 16'(v);
  endfunction

  // Convert one sample, try to overwrite the result, read it back
  task automatic sample(input logic signed [23:0] raw, input logic uni, input logic ob);
    logic [15:0] exp_val;
    exp_val = expect_result(raw, uni, ob);
    unipolar_sel = uni;
    offset_binary_sel = ob;
    raw_sample = raw;
    sample_valid = 1'b1;
    @(negedge ref_clk);
    sample_valid = 1'b0;
    check({23'h000000, result_valid}, 24'h000001);
    wr(ADDR_RESULT, 24, {~exp_val, 8'hFF});
    rd_reg(ADDR_RESULT, 24, rd);
    check(rd, {exp_val, 8'h00});
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    gpio_in = 4'h5;
    unipolar_sel = 1'b0;
    offset_binary_sel = 1'b0;
    sample_valid = 1'b0;
    raw_sample = 24'sh000000;
    cal_busy = 1'b0;
    loads = 4'h0;
    cal_value = 24'h000000;
    ctl3 = CALIB_CONTROL_RST;
    soc = 24'h000000;
    system_gain_coefficient = 24'h000000;
    sco = 24'h000000;
    scg = 24'h000000;
    fail_count = 0;
    check_count = 0;
    void'($urandom(32'hCEF5));
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    repeat (3) @(negedge ref_clk);
    // Reset state, plus an unmapped address
    check({16'h0000, gpio_oe, gpio_out}, 24'h00000F);
    rd_reg(ADDR_GPIO_CONTROL, 8, rd);
    check(rd, {20'h00000, gpio_in});
    rd_reg(ADDR_CALIB_CONTROL, 8, rd);
    check(rd, {16'h0000, CALIB_CONTROL_RST});
    for (int a = 4; a <= 8; a++) begin
      rd_reg(5'(a), 24, rd);
      check(rd, 24'h000000);
    end
    rd_reg(5'h1F, 8, rd);
    check(rd, 24'h000000);
    // Pin direction and level, slow host
    spi_host_model_inst.half = 9;
    for (int i = 0; i < 6; i++) begin
      v8 = (i == 0) ? 8'h3A : 8'($urandom);
      gpio_in = 4'($urandom);
      wr(ADDR_GPIO_CONTROL, 8, {16'h0000, v8});
      check({16'h0000, gpio_oe, gpio_out}, {16'h0000, v8});
      rd_reg(ADDR_GPIO_CONTROL, 8, rd);
      check(rd, {16'h0000, v8[7:4], (v8[7:4] & v8[3:0]) | (~v8[7:4] & gpio_in)});
    end
    spi_host_model_inst.half = 6;
    // Format corners with every correction off
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 5; c++) begin
        sample(corner[c], m == 0, m == 2);
      end
    end
    // Every gain code with random corrections and coefficients
    for (int g = 0; g < 8; g++) begin
      ctl3 = {3'(g), 4'($urandom), 1'b0};
      wr(ADDR_CALIB_CONTROL, 8, {16'h0000, ctl3 | 8'h01});
      rd_reg(ADDR_CALIB_CONTROL, 8, rd);
      check(rd, {16'h0000, ctl3});
      soc = 24'($signed(16'($urandom)));
      wr(ADDR_SYS_OFFSET, 24, soc);
      rd_reg(ADDR_SYS_OFFSET, 24, rd);
      check(rd, soc);
      system_gain_coefficient = 24'h400000 + 24'($urandom_range(32'h007FFFFF));
      wr(ADDR_SYS_GAIN, 24, 24'($urandom));
      pulse_load(1, system_gain_coefficient);
      rd_reg(ADDR_SYS_GAIN, 24, rd);
      check(rd, system_gain_coefficient);
      sco = 24'($signed(16'($urandom)));
      scg = 24'h400000 + 24'($urandom_range(32'h007FFFFF));
      pulse_load(2, sco);
      pulse_load(3, scg);
      // Self gain write while calibrating must be dropped
      cal_busy = 1'b1;
      wr(ADDR_SELF_GAIN, 24, ~scg);
      cal_busy = 1'b0;
      rd_reg(ADDR_SELF_GAIN, 24, rd);
      check(rd, scg);
      for (int s = 0; s < 3; s++) begin
        sample(24'($signed(24'($urandom)) >>> g), 1'($urandom), 1'($urandom));
      end
    end
    summarize();
  end
endmodule
